// ### dbfp_pkg.sv
// shared constants, types and helpers of the dual buck fault protection block
package dbfp_pkg;
	// timing base
	localparam int CLK_PERIOD_NS = 25;
	localparam int SW_PERIOD_NS = 1000;
	localparam int SS_TIME_US = 4000;
	localparam int TICK_CYCLES = SW_PERIOD_NS / CLK_PERIOD_NS;
	localparam int SS_TICKS_DFLT = (SS_TIME_US * 1000) / SW_PERIOD_NS;

	// event counters and reference ramp
	localparam int CNT_W = 4;
	localparam logic [CNT_W-1:0] CNT_MAX = 4'hf;
	localparam logic [CNT_W-1:0] CNT_ZERO = 4'h0;
	localparam int REF_W = 8;
	localparam logic [REF_W-1:0] REF_STEPS = 8'hfa;
	localparam logic [REF_W-1:0] REF_ZERO = 8'h00;

	// current sense words: one lsb is 125 mA, each 1 A block adds 2 A of limit
	localparam int CUR_W = 8;
	localparam logic [CUR_W-1:0] LIMIT_PER_BLOCK = 8'h10;
	localparam logic [2:0] TOTAL_BLOCKS = 3'h6;

	// register map, byte addresses
	localparam int ADDR_W = 4;
	localparam int DATA_W = 32;
	localparam logic [ADDR_W-1:0] REG_CTRL = 4'h0;
	localparam logic [ADDR_W-1:0] REG_STATUS = 4'h4;
	localparam logic [ADDR_W-1:0] REG_COUNT = 4'h8;
	localparam int CTRL_RUN_BIT = 0;
	localparam logic CTRL_RUN_RST = 1'b1;
	localparam int STAT_STATE_LSB = 0;
	localparam int STAT_THERM_BIT = 3;
	localparam int STAT_UVF_BIT = 4;
	localparam int STAT_OCF_BIT = 5;
	localparam int STAT_PGA_BIT = 6;
	localparam int STAT_PGB_BIT = 7;
	localparam int CNT_UV_LSB = 0;
	localparam int CNT_OC_LSB = 4;
	localparam int CNT_CFG_LSB = 8;

	// sequencer states, gray along off, soft-start, run, cool-down
	typedef enum logic [2:0] {
		ST_OFF = 3'h0,
		ST_SOFT = 3'h1,
		ST_RUN = 3'h3,
		ST_COOL = 3'h2,
		ST_THERM = 3'h6
	} dbfp_state_t;

	// blocks owned by channel a (master included) for each strap code
	function automatic logic [2:0] blocks_a(input logic [1:0] sel);
		case (sel)
			2'h0: blocks_a = 3'h3;
			2'h1: blocks_a = 3'h2;
			2'h2: blocks_a = 3'h4;
			default: blocks_a = 3'h1;
		endcase
	endfunction

	// overcurrent limit word for a channel owning the given blocks
	function automatic logic [CUR_W-1:0] cur_limit(input logic [2:0] blocks);
		cur_limit = {5'h00, blocks} * LIMIT_PER_BLOCK;
	endfunction

	// adds up to two events to a counter, five bits so overflow shows
	function automatic logic [CNT_W:0] add_events(input logic [CNT_W-1:0] cnt,
		input logic ev_a, input logic ev_b);
		add_events = {1'b0, cnt} + {4'h0, ev_a} + {4'h0, ev_b};
	endfunction
endpackage

// ### dbfp_sync_if.sv
// bundle between the raw pin inputs and their filtered copies
`timescale 1ns/100ps
interface dbfp_sync_if #(parameter int W = 1);
	logic [W-1:0] raw;
	logic [W-1:0] clean;
	modport filt (input raw, output clean);
	modport user (output raw, input clean);
endinterface

// ### dbfp_sync.sv
// three-flop synchroniser with agreement filter for asynchronous inputs
`timescale 1ns/100ps
module dbfp_sync #(
	parameter int W = 1
) (
	input wire logic ref_clk,
	input wire logic reset,
	dbfp_sync_if.filt sif
);
	logic [W-1:0] s1_q;
	logic [W-1:0] s2_q;
	logic [W-1:0] s3_q;
	logic [W-1:0] clean_q;
	logic [W-1:0] clean_d;
	logic [W-1:0] agree;

	// elaboration check on the width
	if (W < 1)
	begin : g_bad_w
		$error("dbfp_sync: width must be at least one");
	end

	// a bit follows the pin only while the second and third stage agree
	always_comb
	begin
		agree = ~(s2_q ^ s3_q);
		clean_d = (s2_q & agree) | (clean_q & ~agree);
	end

	// shift chain, first stage read only by the second
	always_ff @(posedge ref_clk or posedge reset)
	begin
		if (reset)
		begin
			s1_q <= '0;
			s2_q <= '0;
			s3_q <= '0;
			clean_q <= '0;
		end
		else
		begin
			s1_q <= sif.raw;
			s2_q <= s1_q;
			s3_q <= s2_q;
			clean_q <= clean_d;
		end
	end

	assign sif.clean = clean_q;
endmodule

// ### dbfp_top.sv
// fault supervision and hiccup sequencer for a two-channel buck regulator
//
// Behaviour
// - any channel undervoltage in a run-state switching cycle bumps the shared 4-bit counter.
// - both channels undervoltage in one cycle add two counts.
// - undervoltage counter overflow shuts both channels down.
// - undervoltage clears only when the hysteretic comparator releases.
// - one channel recovering does not clear the counter while the other is low.
// - overvoltage drops that channel's output valid until the comparator releases.
// - one overcurrent sample per switching cycle from each master block.
// - each extra 1A block raises the channel limit by 2A.
// - a sample above the limit adds one count to the shared overcurrent counter.
// - current back below the limit before overflow clears the counter.
// - both channels over the limit in one cycle add two counts.
// - overcurrent counter at all ones shuts both channels down.
// - both channels below the limit clear the overcurrent counter.
// - after overcurrent shutdown wait a cool-down as long as soft-start.
// - the overcurrent counter clears as the cool-down starts.
// - cool-down expiry starts a normal soft-start on both channels.
// - successful soft-start on both raises output valid, normal operation.
// - during restart only a fresh overflow shuts down; hiccup repeats forever.
// - over-temperature shuts both channels and sets a holding latch.
// - the thermal latch clears only through power-on reset.
// - soft-start and cool-down last 4 ms, reference stepped gradually.
// - switching cycles come from a 1 MHz internal tick.
// - output valid stays low in shutdown and cool-down.
`timescale 1ns/100ps
module dbfp_top #(
	parameter int SS_TICKS = dbfp_pkg::SS_TICKS_DFLT
) (
	input wire logic ref_clk,
	input wire logic reset,
	input wire logic [dbfp_pkg::ADDR_W-1:0] reg_addr,
	input wire logic [dbfp_pkg::DATA_W-1:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [dbfp_pkg::DATA_W-1:0] reg_rdata,
	input wire logic undervoltage_event_a,
	input wire logic undervoltage_event_b,
	input wire logic overvoltage_event_a,
	input wire logic overvoltage_event_b,
	input wire logic over_temp,
	input wire logic block_config_sel_a,
	input wire logic block_config_sel_b,
	input wire logic [dbfp_pkg::CUR_W-1:0] current_sample_a,
	input wire logic [dbfp_pkg::CUR_W-1:0] current_sample_b,
	output logic channel_on_a,
	output logic channel_on_b,
	output logic [dbfp_pkg::REF_W-1:0] ref_level,
	output logic output_valid_a,
	output logic output_valid_b
);
	localparam int STEP_TICKS = SS_TICKS / int'(dbfp_pkg::REF_STEPS);
	localparam int STEP_W = 12;
	localparam logic [STEP_W-1:0] STEP_LAST = STEP_W'(STEP_TICKS - 1);
	localparam int TICK_W = $clog2(dbfp_pkg::TICK_CYCLES);
	localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(dbfp_pkg::TICK_CYCLES - 1);
	localparam int SYNC_W = 7;

	// elaboration checks on the ramp length
	if (STEP_TICKS < 1 || STEP_TICKS > 4095)
	begin : g_bad_step
		$error("dbfp_top: SS_TICKS gives an unusable ramp step");
	end
	if (SS_TICKS % int'(dbfp_pkg::REF_STEPS) != 0)
	begin : g_bad_mult
		$error("dbfp_top: SS_TICKS must be a multiple of the ramp steps");
	end

	// synchronised pin indications
	dbfp_sync_if #(.W(SYNC_W)) sync_bus ();
	logic uv_a;
	logic uv_b;
	logic ov_a;
	logic ov_b;
	logic otemp;
	logic [1:0] cfg_pins;

	assign sync_bus.raw = {undervoltage_event_a, undervoltage_event_b, overvoltage_event_a,
		overvoltage_event_b, over_temp, block_config_sel_b, block_config_sel_a};
	assign {uv_a, uv_b, ov_a, ov_b, otemp, cfg_pins} = sync_bus.clean;

	dbfp_sync #(.W(SYNC_W)) u_sync (
		.ref_clk(ref_clk),
		.reset(reset),
		.sif(sync_bus)
	);

	// switching-cycle tick divider
	logic [TICK_W-1:0] tick_cnt_q;
	logic [TICK_W-1:0] tick_cnt_d;
	logic tick_q;
	logic tick_d;

	always_comb
	begin
		tick_d = (tick_cnt_q == TICK_LAST);
		tick_cnt_d = tick_d ? '0 : tick_cnt_q + 1'b1;
	end

	always_ff @(posedge ref_clk or posedge reset)
	begin
		if (reset)
		begin
			tick_cnt_q <= '0;
			tick_q <= 1'b0;
		end
		else
		begin
			tick_cnt_q <= tick_cnt_d;
			tick_q <= tick_d;
		end
	end

	// register file state
	logic run_q;
	logic run_d;
	logic [dbfp_pkg::DATA_W-1:0] rdata_q;
	logic [dbfp_pkg::DATA_W-1:0] rdata_d;
	logic clr_uvf;
	logic clr_ocf;

	// sequencer state
	dbfp_pkg::dbfp_state_t state_q;
	dbfp_pkg::dbfp_state_t state_d;
	logic [dbfp_pkg::CNT_W-1:0] uv_cnt_q;
	logic [dbfp_pkg::CNT_W-1:0] uv_cnt_d;
	logic [dbfp_pkg::CNT_W-1:0] oc_cnt_q;
	logic [dbfp_pkg::CNT_W-1:0] oc_cnt_d;
	logic [STEP_W-1:0] step_q;
	logic [STEP_W-1:0] step_d;
	logic [dbfp_pkg::REF_W-1:0] prog_q;
	logic [dbfp_pkg::REF_W-1:0] prog_d;
	logic [1:0] cfg_q;
	logic [1:0] cfg_d;
	logic cfg_valid_q;
	logic cfg_valid_d;
	logic therm_q;
	logic therm_d;
	logic uvf_q;
	logic uvf_d;
	logic ocf_q;
	logic ocf_d;
	logic chan_on_q;
	logic chan_on_d;
	logic [dbfp_pkg::REF_W-1:0] ref_q;
	logic [dbfp_pkg::REF_W-1:0] ref_d;
	logic pg_a_q;
	logic pg_a_d;
	logic pg_b_q;
	logic pg_b_d;

	// helpers of the sequencer
	logic [2:0] blk_a;
	logic [2:0] blk_b;
	logic [dbfp_pkg::CUR_W-1:0] lim_a;
	logic [dbfp_pkg::CUR_W-1:0] lim_b;
	logic oc_a;
	logic oc_b;
	logic [dbfp_pkg::CNT_W:0] uv_sum;
	logic [dbfp_pkg::CNT_W:0] oc_sum;
	logic uv_trip;
	logic oc_trip;
	logic ramp_done;

	// limits follow the strap code captured once after reset
	always_comb
	begin
		blk_a = dbfp_pkg::blocks_a(cfg_q);
		blk_b = dbfp_pkg::TOTAL_BLOCKS - blk_a;
		lim_a = dbfp_pkg::cur_limit(blk_a);
		lim_b = dbfp_pkg::cur_limit(blk_b);
		oc_a = current_sample_a > lim_a;
		oc_b = current_sample_b > lim_b;
		uv_sum = dbfp_pkg::add_events(uv_cnt_q, uv_a, uv_b);
		oc_sum = dbfp_pkg::add_events(oc_cnt_q, oc_a, oc_b);
		uv_trip = uv_sum > {1'b0, dbfp_pkg::CNT_MAX};
		oc_trip = oc_sum >= {1'b0, dbfp_pkg::CNT_MAX};
		ramp_done = (step_q == STEP_LAST) && (prog_q == dbfp_pkg::REF_STEPS - 1'b1);
	end

	// fault counters, hiccup sequencer and registered outputs
	always_comb
	begin
		state_d = state_q;
		uv_cnt_d = uv_cnt_q;
		oc_cnt_d = oc_cnt_q;
		step_d = step_q;
		prog_d = prog_q;
		cfg_d = cfg_q;
		cfg_valid_d = cfg_valid_q;
		therm_d = therm_q;
		uvf_d = uvf_q & ~clr_uvf;
		ocf_d = ocf_q & ~clr_ocf;
		if (tick_q)
		begin
			if (!cfg_valid_q)
			begin
				cfg_d = cfg_pins;
				cfg_valid_d = 1'b1;
			end
			// ramp progress shared by soft-start and cool-down
			if (step_q == STEP_LAST)
			begin
				step_d = '0;
				prog_d = prog_q + 1'b1;
			end
			else
				step_d = step_q + 1'b1;
			case (state_q)
				dbfp_pkg::ST_OFF:
				begin
					step_d = '0;
					prog_d = dbfp_pkg::REF_ZERO;
					if (run_q && cfg_valid_q)
						state_d = dbfp_pkg::ST_SOFT;
				end
				dbfp_pkg::ST_SOFT:
				begin
					if (ramp_done)
						state_d = dbfp_pkg::ST_RUN;
				end
				dbfp_pkg::ST_RUN:
				begin
					step_d = '0;
					prog_d = dbfp_pkg::REF_ZERO;
					// counter only clears with no channel low
					if (!uv_a && !uv_b)
						uv_cnt_d = dbfp_pkg::CNT_ZERO;
					else
						uv_cnt_d = uv_sum[dbfp_pkg::CNT_W-1:0];
				end
				dbfp_pkg::ST_COOL:
				begin
					if (ramp_done)
					begin
						state_d = dbfp_pkg::ST_SOFT;
						step_d = '0;
						prog_d = dbfp_pkg::REF_ZERO;
					end
				end
				dbfp_pkg::ST_THERM:
				begin
					step_d = '0;
					prog_d = dbfp_pkg::REF_ZERO;
				end
				default:
					state_d = dbfp_pkg::ST_OFF;
			endcase
			// overcurrent counting on soft-start and run
			if (state_q == dbfp_pkg::ST_SOFT || state_q == dbfp_pkg::ST_RUN)
			begin
				if (!oc_a && !oc_b)
					oc_cnt_d = dbfp_pkg::CNT_ZERO;
				else if (oc_trip)
					oc_cnt_d = dbfp_pkg::CNT_MAX;
				else
					oc_cnt_d = oc_sum[dbfp_pkg::CNT_W-1:0];
				if (oc_trip || (state_q == dbfp_pkg::ST_RUN && uv_trip && (uv_a || uv_b)))
				begin
					// shut down both channels and enter cool-down
					state_d = dbfp_pkg::ST_COOL;
					oc_cnt_d = dbfp_pkg::CNT_ZERO;
					uv_cnt_d = dbfp_pkg::CNT_ZERO;
					step_d = '0;
					prog_d = dbfp_pkg::REF_ZERO;
					ocf_d = oc_trip | ocf_d;
					uvf_d = (state_q == dbfp_pkg::ST_RUN && uv_trip) | uvf_d;
				end
			end
			// software stop returns to off without a latch
			if (!run_q && state_q != dbfp_pkg::ST_THERM)
			begin
				state_d = dbfp_pkg::ST_OFF;
				oc_cnt_d = dbfp_pkg::CNT_ZERO;
				uv_cnt_d = dbfp_pkg::CNT_ZERO;
			end
			// thermal trip wins over all and never leaves
			if (otemp || therm_q)
			begin
				state_d = dbfp_pkg::ST_THERM;
				therm_d = 1'b1;
			end
		end
		chan_on_d = (state_d == dbfp_pkg::ST_SOFT) || (state_d == dbfp_pkg::ST_RUN);
		case (state_d)
			dbfp_pkg::ST_SOFT: ref_d = prog_d;
			dbfp_pkg::ST_RUN: ref_d = dbfp_pkg::REF_STEPS;
			default: ref_d = dbfp_pkg::REF_ZERO;
		endcase
		// output valid only in run and inside the window
		pg_a_d = (state_d == dbfp_pkg::ST_RUN) && !ov_a && !uv_a;
		pg_b_d = (state_d == dbfp_pkg::ST_RUN) && !ov_b && !uv_b;
	end

	always_ff @(posedge ref_clk or posedge reset)
	begin
		if (reset)
		begin
			state_q <= dbfp_pkg::ST_OFF;
			uv_cnt_q <= dbfp_pkg::CNT_ZERO;
			oc_cnt_q <= dbfp_pkg::CNT_ZERO;
			step_q <= '0;
			prog_q <= dbfp_pkg::REF_ZERO;
			cfg_q <= 2'h0;
			cfg_valid_q <= 1'b0;
			therm_q <= 1'b0;
			uvf_q <= 1'b0;
			ocf_q <= 1'b0;
			chan_on_q <= 1'b0;
			ref_q <= dbfp_pkg::REF_ZERO;
			pg_a_q <= 1'b0;
			pg_b_q <= 1'b0;
		end
		else
		begin
			state_q <= state_d;
			uv_cnt_q <= uv_cnt_d;
			oc_cnt_q <= oc_cnt_d;
			step_q <= step_d;
			prog_q <= prog_d;
			cfg_q <= cfg_d;
			cfg_valid_q <= cfg_valid_d;
			therm_q <= therm_d;
			uvf_q <= uvf_d;
			ocf_q <= ocf_d;
			chan_on_q <= chan_on_d;
			ref_q <= ref_d;
			pg_a_q <= pg_a_d;
			pg_b_q <= pg_b_d;
		end
	end

	// register bus: control write, sticky clears, read mux with one-cycle latency
	always_comb
	begin
		run_d = run_q;
		clr_uvf = 1'b0;
		clr_ocf = 1'b0;
		rdata_d = '0;
		if (reg_wr)
		begin
			case (reg_addr)
				dbfp_pkg::REG_CTRL: run_d = reg_wdata[dbfp_pkg::CTRL_RUN_BIT];
				dbfp_pkg::REG_STATUS:
				begin
					clr_uvf = reg_wdata[dbfp_pkg::STAT_UVF_BIT];
					clr_ocf = reg_wdata[dbfp_pkg::STAT_OCF_BIT];
				end
				default: run_d = run_q;
			endcase
		end
		if (reg_rd)
		begin
			case (reg_addr)
				dbfp_pkg::REG_CTRL: rdata_d[dbfp_pkg::CTRL_RUN_BIT] = run_q;
				dbfp_pkg::REG_STATUS:
				begin
					rdata_d[dbfp_pkg::STAT_STATE_LSB +: 3] = state_q;
					rdata_d[dbfp_pkg::STAT_THERM_BIT] = therm_q;
					rdata_d[dbfp_pkg::STAT_UVF_BIT] = uvf_q;
					rdata_d[dbfp_pkg::STAT_OCF_BIT] = ocf_q;
					rdata_d[dbfp_pkg::STAT_PGA_BIT] = pg_a_q;
					rdata_d[dbfp_pkg::STAT_PGB_BIT] = pg_b_q;
				end
				dbfp_pkg::REG_COUNT:
				begin
					rdata_d[dbfp_pkg::CNT_UV_LSB +: dbfp_pkg::CNT_W] = uv_cnt_q;
					rdata_d[dbfp_pkg::CNT_OC_LSB +: dbfp_pkg::CNT_W] = oc_cnt_q;
					rdata_d[dbfp_pkg::CNT_CFG_LSB +: 2] = cfg_q;
				end
				default: rdata_d = '0;
			endcase
		end
	end

	always_ff @(posedge ref_clk or posedge reset)
	begin
		if (reset)
		begin
			run_q <= dbfp_pkg::CTRL_RUN_RST;
			rdata_q <= '0;
		end
		else
		begin
			run_q <= run_d;
			rdata_q <= rdata_d;
		end
	end

	// all outputs straight from flops
	assign reg_rdata = rdata_q;
	assign channel_on_a = chan_on_q;
	assign channel_on_b = chan_on_q;
	assign ref_level = ref_q;
	assign output_valid_a = pg_a_q;
	assign output_valid_b = pg_b_q;
endmodule

// ### dbfp_top_properties.sv
// port assertions of the fault sequencer, bound into the top module
`timescale 1ns/100ps
module dbfp_chk #(
	parameter int SS_TICKS = 250
) (
	input wire logic ref_clk,
	input wire logic reset,
	input wire logic overvoltage_event_a,
	input wire logic over_temp,
	input wire logic channel_on_a,
	input wire logic channel_on_b,
	input wire logic [dbfp_pkg::REF_W-1:0] ref_level,
	input wire logic output_valid_a,
	input wire logic output_valid_b
);
	localparam int MIN_OFF = (SS_TICKS - 1) * dbfp_pkg::TICK_CYCLES;
	logic [15:0] off_q;
	logic [15:0] off_d;
	logic seen_q;
	logic seen_d;
	// cycles off since the channels last ran, and whether they ever ran
	always_comb
	begin
		off_d = channel_on_a ? 16'h0000 : off_q + 16'h0001;
		seen_d = seen_q | channel_on_a;
	end
	always_ff @(posedge ref_clk or posedge reset)
	begin
		if (reset)
		begin
			off_q <= 16'h0000;
			seen_q <= 1'b0;
		end
		else
		begin
			off_q <= off_d;
			seen_q <= seen_d;
		end
	end
	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (reset);
	property p_pair;
		channel_on_a == channel_on_b;
	endproperty
	a_pair: assert property (p_pair) else $error("channels differ");
	property p_dark;
		!channel_on_a |-> !output_valid_a && !output_valid_b;
	endproperty
	a_dark: assert property (p_dark) else $error("valid while off");
	property p_refoff;
		!channel_on_a |-> ref_level == dbfp_pkg::REF_ZERO;
	endproperty
	a_refoff: assert property (p_refoff) else $error("reference while off");
	property p_step;
		channel_on_a && $past(channel_on_a) |-> ref_level - $past(ref_level) <= 8'h01;
	endproperty
	a_step: assert property (p_step) else $error("reference jumped");
	property p_good;
		$rose(output_valid_a) |-> ref_level == dbfp_pkg::REF_STEPS;
	endproperty
	a_good: assert property (p_good) else $error("valid before ramp end");
	property p_start;
		$rose(channel_on_a) |-> ref_level == dbfp_pkg::REF_ZERO;
	endproperty
	a_start: assert property (p_start) else $error("ramp not from zero");
	property p_ov;
		overvoltage_event_a [*8] |-> !output_valid_a;
	endproperty
	a_ov: assert property (p_ov) else $error("valid during overvoltage");
	property p_hot;
		over_temp [*8] |-> ##[0:50] !channel_on_a;
	endproperty
	a_hot: assert property (p_hot) else $error("no thermal shutdown");
	property p_cool;
		$rose(channel_on_a) && seen_q |-> int'(off_q) >= MIN_OFF;
	endproperty
	a_cool: assert property (p_cool) else $error("restart too early");
endmodule
bind dbfp_top dbfp_chk #(.SS_TICKS(SS_TICKS)) u_chk (
	.ref_clk(ref_clk),
	.reset(reset),
	.overvoltage_event_a(overvoltage_event_a),
	.over_temp(over_temp),
	.channel_on_a(channel_on_a),
	.channel_on_b(channel_on_b),
	.ref_level(ref_level),
	.output_valid_a(output_valid_a),
	.output_valid_b(output_valid_b)
);

// ### dbfp_plant.sv
// behavioural comparators, current sense and power stage
`timescale 1ns/100ps
module dbfp_plant (
	input wire logic pwr_on,
	input wire logic [1:0] uv_req,
	input wire logic [1:0] ov_req,
	input wire logic hot_req,
	input wire logic [7:0] load_a,
	input wire logic [7:0] load_b,
	output logic uv_a,
	output logic uv_b,
	output logic ov_a,
	output logic ov_b,
	output logic hot,
	output logic [7:0] cur_a,
	output logic [7:0] cur_b
);
	// output sags while the stage is off, comparator holds until released
	assign uv_a = uv_req[0] | !pwr_on;
	assign uv_b = uv_req[1] | !pwr_on;
	assign ov_a = ov_req[0];
	assign ov_b = ov_req[1];
	assign hot = hot_req;
	// no current flows through a stopped stage
	assign cur_a = pwr_on ? load_a : 8'h00;
	assign cur_b = pwr_on ? load_b : 8'h00;
endmodule

// ### test_dual_buck_fault_protection.sv
// self-checking bench of the fault sequencer
`timescale 1ns/100ps
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin fail_count++; \
	$display("MISMATCH %0t got %h exp %h", $time, g, e); end end
module test_dual_buck_fault_protection;
	logic ref_clk = 1'b0;
	logic reset = 1'b1;
	logic [3:0] reg_addr = 4'h0;
	logic [31:0] reg_wdata = 32'h0000_0000;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic [1:0] uv = 2'h0;
	logic [1:0] ov = 2'h0;
	logic hot = 1'b0;
	logic [7:0] la = 8'h00;
	logic [7:0] lb = 8'h00;
	logic [1:0] strap = 2'h0;
	logic [31:0] reg_rdata;
	logic uv_a, uv_b, ov_a, ov_b, ot, on_a, on_b, pg_a, pg_b;
	logic [7:0] ca, cb, ref_level;
	int fail_count = 0;
	int n_tests = 0;
	int cyc = 0;
	always #12.5 ref_clk = ~ref_clk;
	dbfp_plant u_plant (.pwr_on(on_a), .uv_req(uv), .ov_req(ov), .hot_req(hot), .load_a(la),
		.load_b(lb), .uv_a(uv_a), .uv_b(uv_b), .ov_a(ov_a), .ov_b(ov_b), .hot(ot),
		.cur_a(ca), .cur_b(cb));
	dbfp_top #(.SS_TICKS(250)) DUT (.ref_clk(ref_clk), .reset(reset), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.undervoltage_event_a(uv_a), .undervoltage_event_b(uv_b),
		.overvoltage_event_a(ov_a), .overvoltage_event_b(ov_b), .over_temp(ot),
		.block_config_sel_a(strap[0]), .block_config_sel_b(strap[1]),
		.current_sample_a(ca), .current_sample_b(cb), .channel_on_a(on_a),
		.channel_on_b(on_b), .ref_level(ref_level), .output_valid_a(pg_a),
		.output_valid_b(pg_b));
	task automatic stop_test;
		$display("checks %0d mismatches %0d", n_tests, fail_count);
		if (fail_count == 0 && n_tests > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	// hang guard
	always @(posedge ref_clk)
	begin
		cyc++;
		if (cyc == 90000)
		begin
			fail_count++;
			stop_test();
		end
	end
	task automatic tk(input int n);
		repeat (n) @(posedge ref_clk);
	endtask
	// bus cycles, each returning on a rising edge
	task automatic wr(input logic [3:0] a, input logic [31:0] v);
		@(posedge ref_clk);
		reg_addr <= a;
		reg_wdata <= v;
		reg_wr <= 1'b1;
		@(posedge ref_clk);
		reg_wr <= 1'b0;
	endtask
	task automatic rd(input logic [3:0] a, output logic [31:0] d);
		@(posedge ref_clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge ref_clk);
		reg_rd <= 1'b0;
		@(negedge ref_clk);
		d = reg_rdata;
		@(posedge ref_clk);
	endtask
	task automatic field(input int lsb, output logic [3:0] v);
		logic [31:0] d;
		rd(dbfp_pkg::REG_COUNT, d);
		v = d[lsb+:4];
	endtask
	// returns just after a counter moves
	task automatic sync_tick(input int lsb, output logic [3:0] v);
		logic [3:0] p;
		field(lsb, p);
		v = p;
		for (int i = 0; i < 30 && v === p; i++)
			field(lsb, v);
	endtask
	task automatic wait_st(input logic [2:0] s, input int n);
		logic [31:0] d;
		rd(dbfp_pkg::REG_STATUS, d);
		while (d[2:0] !== s && n > 0)
		begin
			tk(37);
			rd(dbfp_pkg::REG_STATUS, d);
			n--;
		end
		`CHK(d[2:0], s)
	endtask
	task automatic t_start;
		logic [31:0] d;
		rd(dbfp_pkg::REG_CTRL, d);
		`CHK(d, 32'h0000_0001)
		rd(4'hc, d);
		`CHK(d, 32'h0000_0000)
		wait_st(dbfp_pkg::ST_RUN, 300);
		`CHK(ref_level, dbfp_pkg::REF_STEPS)
		`CHK({pg_a, pg_b}, 2'b11)
	endtask
	task automatic t_ov;
		ov <= 2'b01;
		tk(20);
		`CHK({pg_a, pg_b}, 2'b01)
		ov <= 2'b00;
		tk(20);
		`CHK(pg_a, 1'b1)
	endtask
	task automatic t_uv;
		logic [3:0] v;
		logic [3:0] w;
		logic [31:0] d;
		uv <= 2'b11;
		sync_tick(0, v);
		tk(38);
		field(0, w);
		`CHK(w, v + 4'h2)
		uv <= 2'b01;
		tk(38);
		field(0, v);
		`CHK(v, w + 4'h1)
		uv <= 2'b00;
		tk(80);
		field(0, v);
		`CHK(v, 4'h0)
		uv <= 2'b01;
		wait_st(dbfp_pkg::ST_COOL, 20);
		rd(dbfp_pkg::REG_STATUS, d);
		`CHK({d[4], on_a, on_b, pg_a}, 4'b1000)
		uv <= 2'b00;
		wait_st(dbfp_pkg::ST_RUN, 520);
	endtask
	task automatic t_hot;
		logic [31:0] d;
		hot <= 1'b1;
		tk(100);
		rd(dbfp_pkg::REG_STATUS, d);
		`CHK({d[3:0], on_a}, 5'h1c)
		hot <= 1'b0;
		tk(200);
		rd(dbfp_pkg::REG_STATUS, d);
		`CHK(d[3:0], 4'he)
		strap <= 2'b10;
		reset <= 1'b1;
		tk(6);
		reset <= 1'b0;
		rd(dbfp_pkg::REG_STATUS, d);
		`CHK(d[3:0], 4'h0)
		tk(100);
		rd(dbfp_pkg::REG_COUNT, d);
		`CHK(d[9:8], 2'b10)
	endtask
	task automatic t_oc;
		logic [3:0] v;
		logic [3:0] w;
		logic [31:0] d;
		la <= 8'h40;
		lb <= 8'h20;
		tk(100);
		field(4, v);
		`CHK(v, 4'h0)
		la <= 8'h41;
		sync_tick(4, v);
		tk(38);
		field(4, w);
		`CHK(w, v + 4'h1)
		lb <= 8'h21;
		tk(38);
		field(4, v);
		`CHK(v, w + 4'h2)
		la <= 8'h40;
		lb <= 8'h20;
		tk(38);
		field(4, w);
		`CHK(w, 4'h0)
		la <= 8'h41;
		wait_st(dbfp_pkg::ST_COOL, 20);
		rd(dbfp_pkg::REG_COUNT, d);
		`CHK(d[7:4], 4'h0)
		rd(dbfp_pkg::REG_STATUS, d);
		`CHK(d[5], 1'b1)
		wr(dbfp_pkg::REG_STATUS, 32'h0000_0020);
		rd(dbfp_pkg::REG_STATUS, d);
		`CHK(d[5], 1'b0)
		wait_st(dbfp_pkg::ST_SOFT, 260);
		tk(400);
		wait_st(dbfp_pkg::ST_SOFT, 0);
		wait_st(dbfp_pkg::ST_COOL, 10);
		la <= 8'h00;
		wait_st(dbfp_pkg::ST_SOFT, 260);
		wait_st(dbfp_pkg::ST_RUN, 260);
		`CHK({pg_a, pg_b}, 2'b11)
	endtask
	initial
	begin
		tk(6);
		reset <= 1'b0;
		t_start();
		t_ov();
		t_uv();
		t_hot();
		t_oc();
		stop_test();
	end
endmodule
